// File: design/ddr_cmd_cfg.svh
`ifndef DDR_CMD_CFG_SVH
`define DDR_CMD_CFG_SVH
// extended mode word bit positions, then the auto-precharge address bit
`define EMR_DLL_OFF_BIT 0
`define EMR_DRV_LO_BIT 1
`define EMR_DRV_HI_BIT 6
`define EMR_TEST_BIT 7
`define EMR_RSV0_BIT 9
`define EMR_RSV1_BIT 10
`define EMR_RSV2_BIT 11
`define ADDR_AP_BIT 10
// drive strength codes {a6,a1}
`define DRV_FULL 2'h0
`define DRV_60 2'h1
`define DRV_RSVD 2'h2
`define DRV_30 2'h3
// bank selects for mode set
`define BA_MODE 2'h0
`define BA_EXT_MODE 2'h1
// controller register map (axi4-lite byte addresses)
`define REG_CMD 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hc
`endif

// File: design/ddr_cmd_pkg.sv
package ddr_cmd_pkg;
	typedef enum logic [3:0] {
		cmd_deselect = 4'h0,
		cmd_nop = 4'h1,
		cmd_activate = 4'h2,
		cmd_precharge = 4'h3,
		cmd_read = 4'h4,
		cmd_write = 4'h5,
		cmd_mode_set = 4'h6,
		cmd_refresh = 4'h7,
		cmd_burst_stop = 4'h8
	} cmd_t;
	typedef enum logic [1:0] {
		pwr_normal = 2'h0,
		pwr_down = 2'h1,
		pwr_self_refresh = 2'h2
	} pwr_t;
endpackage

// File: design/ddr_cmd_if.sv
`timescale 1ns/1ps
interface ddr_cmd_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic [1:0] ba;
	logic [11:0] addr;
	logic lower_byte_mask;
	logic upper_byte_mask;
	logic [15:0] dq;
	modport controller(output cs_n, ras_n, cas_n, we_n, cke, ba, addr, lower_byte_mask,
		upper_byte_mask, dq);
	modport memory(input cs_n, ras_n, cas_n, we_n, cke, ba, addr, lower_byte_mask,
		upper_byte_mask, dq);
endinterface

// File: design/ddr_cmd_device.sv
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ddr_cmd_cfg.svh"
module ddr_cmd_device #(
	parameter int BANKS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	// link from controller
	ddr_cmd_if.memory link,
	// decoded view
	output logic [3:0] last_cmd,
	output logic cmd_pulse,
	output logic [1:0] pwr_state,
	output logic [11:0] mode_config,
	output logic [11:0] extended_mode_config,
	output logic dll_disabled,
	output logic [1:0] drive_strength,
	output logic test_mode,
	output logic [BANKS-1:0] bank_open,
	output logic illegal_cmd,
	output logic [15:0] write_data,
	output logic [1:0] write_lane_en
);
	ddr_cmd_pkg::cmd_t cmd;
	logic cke_prev_reg;
	logic in_burst_reg;
	logic sel;
	logic ap;
	logic bank_active;
	logic [1:0] bank_idx;

	assign bank_idx = link.ba;
	assign ap = link.addr[`ADDR_AP_BIT];
	assign bank_active = bank_open[bank_idx];

	always_comb begin
		cmd = ddr_cmd_pkg::cmd_nop;
		if (link.cs_n) begin
			cmd = ddr_cmd_pkg::cmd_deselect;
		end else begin
			case ({link.ras_n, link.cas_n, link.we_n})
				3'h3: cmd = ddr_cmd_pkg::cmd_activate;
				3'h2: cmd = ddr_cmd_pkg::cmd_precharge;
				3'h4: cmd = ddr_cmd_pkg::cmd_write;
				3'h5: cmd = ddr_cmd_pkg::cmd_read;
				3'h0: cmd = ddr_cmd_pkg::cmd_mode_set;
				3'h1: cmd = ddr_cmd_pkg::cmd_refresh;
				3'h6: cmd = ddr_cmd_pkg::cmd_burst_stop;
				default: cmd = ddr_cmd_pkg::cmd_nop;
			endcase
		end
	end

	// a command edge counts only if cke was high on the previous edge
	assign sel = cke_prev_reg && pwr_state == ddr_cmd_pkg::pwr_normal;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_prev_reg <= 1'b0;
		end else begin
			cke_prev_reg <= link.cke;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_cmd <= 4'h0;
			cmd_pulse <= 1'b0;
		end else begin
			cmd_pulse <= sel && cmd != ddr_cmd_pkg::cmd_deselect;
			if (sel) begin
				last_cmd <= cmd;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_state <= ddr_cmd_pkg::pwr_normal;
		end else begin
			case (pwr_state)
				ddr_cmd_pkg::pwr_normal: begin
					if (cke_prev_reg && !link.cke) begin
						if (cmd == ddr_cmd_pkg::cmd_refresh) begin
							pwr_state <= ddr_cmd_pkg::pwr_self_refresh;
						end else if ((cmd == ddr_cmd_pkg::cmd_deselect ||
							cmd == ddr_cmd_pkg::cmd_nop) && !in_burst_reg) begin
							pwr_state <= ddr_cmd_pkg::pwr_down;
						end
					end
				end
				default: begin
					// write-enable is a don't-care on exit, so the stop encoding wakes too
					if (!cke_prev_reg && link.cke && (link.cs_n ||
						(link.ras_n && link.cas_n))) begin
						pwr_state <= ddr_cmd_pkg::pwr_normal;
					end
				end
			endcase
		end
	end

	// mode words are undefined at power up; clear them for a known start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_config <= 12'h000;
			extended_mode_config <= 12'h000;
		end else if (sel && cmd == ddr_cmd_pkg::cmd_mode_set) begin
			if (link.ba == `BA_MODE) begin
				mode_config <= link.addr;
			end else if (link.ba == `BA_EXT_MODE) begin
				extended_mode_config <= link.addr;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dll_disabled <= 1'b0;
			drive_strength <= `DRV_FULL;
			test_mode <= 1'b0;
		end else begin
			dll_disabled <= extended_mode_config[`EMR_DLL_OFF_BIT];
			drive_strength <= {extended_mode_config[`EMR_DRV_HI_BIT],
				extended_mode_config[`EMR_DRV_LO_BIT]};
			test_mode <= extended_mode_config[`EMR_TEST_BIT];
		end
	end

	// bank open table; per-bank update kept in one loop
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				bank_open[b] <= 1'b0;
			end else if (sel) begin
				if (cmd == ddr_cmd_pkg::cmd_activate && bank_idx == b) begin
					bank_open[b] <= 1'b1;
				end else if (cmd == ddr_cmd_pkg::cmd_precharge && (ap || bank_idx == b)) begin
					bank_open[b] <= 1'b0;
				end else if ((cmd == ddr_cmd_pkg::cmd_read || cmd == ddr_cmd_pkg::cmd_write)
					&& ap && bank_idx == b) begin
					bank_open[b] <= 1'b0;
				end
			end
		end
	end

	// burst tracking is coarse: a read/write to an open bank opens it, stop/precharge/nop/deselect ends it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_burst_reg <= 1'b0;
		end else if (sel) begin
			if ((cmd == ddr_cmd_pkg::cmd_read || cmd == ddr_cmd_pkg::cmd_write) &&
				bank_active) begin
				in_burst_reg <= 1'b1;
			end else if (cmd == ddr_cmd_pkg::cmd_burst_stop ||
				cmd == ddr_cmd_pkg::cmd_precharge || cmd == ddr_cmd_pkg::cmd_nop ||
				cmd == ddr_cmd_pkg::cmd_deselect) begin
				in_burst_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			illegal_cmd <= 1'b0;
		end else begin
			illegal_cmd <= 1'b0;
			if (sel) begin
				case (cmd)
					ddr_cmd_pkg::cmd_activate: illegal_cmd <= bank_active;
					ddr_cmd_pkg::cmd_read, ddr_cmd_pkg::cmd_write:
						illegal_cmd <= !bank_active;
					ddr_cmd_pkg::cmd_mode_set:
						illegal_cmd <= |bank_open || link.ba[1];
					ddr_cmd_pkg::cmd_refresh: illegal_cmd <= |bank_open;
					default: illegal_cmd <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_data <= 16'h0000;
			write_lane_en <= 2'h0;
		end else begin
			write_lane_en <= 2'h0;
			if (sel && cmd == ddr_cmd_pkg::cmd_write && bank_active) begin
				write_data <= link.dq;
				write_lane_en <= {!link.upper_byte_mask, !link.lower_byte_mask};
			end
		end
	end
endmodule

// File: design/ddr_cmd_controller.sv
`timescale 1ns/1ps
`include "ddr_cmd_cfg.svh"
module ddr_cmd_controller (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link to memory
	ddr_cmd_if.controller link
);
	logic [3:0] awaddr_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [31:0] wdata_reg;
	logic issue_reg;
	logic [19:0] cmd_word_reg;
	logic [15:0] wdata_out_reg;
	logic [31:0] rdata_next;

	// a command word is {cke,cs,ras,cas,we,ba[1:0],mask,addr[11:0]}... packed low; the one mask bit drives both lanes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata;
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == `REG_STATUS) ? 2'h2 : 2'h0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

	// cmd word: [19]cke [18]cs_n [17]ras_n [16]cas_n [15]we_n [14:13]ba [12]mask [11:0]addr... see below
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_word_reg <= 20'h7c000;
			wdata_out_reg <= 16'h0000;
			issue_reg <= 1'b0;
		end else begin
			issue_reg <= 1'b0;
			if (wr_fire && awaddr_reg == `REG_CMD) begin
				cmd_word_reg <= wdata_reg[19:0];
				issue_reg <= 1'b1;
			end
			if (wr_fire && awaddr_reg == `REG_WDATA) begin
				wdata_out_reg <= wdata_reg[15:0];
			end
		end
	end

	// pins held from registers; software sequences nop after exit and emr rules
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.cke <= 1'b0;
			link.cs_n <= 1'b1;
			link.ras_n <= 1'b1;
			link.cas_n <= 1'b1;
			link.we_n <= 1'b1;
			link.ba <= 2'h0;
			link.addr <= 12'h000;
			link.lower_byte_mask <= 1'b1;
			link.upper_byte_mask <= 1'b1;
			link.dq <= 16'h0000;
		end else if (issue_reg) begin
			link.cke <= cmd_word_reg[19];
			link.cs_n <= cmd_word_reg[18];
			link.ras_n <= cmd_word_reg[17];
			link.cas_n <= cmd_word_reg[16];
			link.we_n <= cmd_word_reg[15];
			link.ba <= cmd_word_reg[14:13];
			// mode set: test and reserved bits forced low for normal operation
			link.addr <= (cmd_word_reg[18:15] == 4'h0) ?
				(cmd_word_reg[11:0] & 12'h17f) : cmd_word_reg[11:0];
			link.lower_byte_mask <= cmd_word_reg[12];
			link.upper_byte_mask <= cmd_word_reg[12];
			link.dq <= wdata_out_reg;
		end else begin
			link.cs_n <= 1'b1; // deselect between issued commands
		end
	end

	always_comb begin
		case (s_axi_araddr)
			`REG_CMD: rdata_next = {12'h000, cmd_word_reg};
			`REG_WDATA: rdata_next = {16'h0000, wdata_out_reg};
			`REG_STATUS: rdata_next = {31'h0, issue_reg};
			default: rdata_next = 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_next;
				s_axi_rresp <= (s_axi_araddr == `REG_ADDR) ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// File: test/ddr_command_decode_emr_properties.sv
`timescale 1ns/1ps
module ddr_command_decode_emr_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link pins
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [1:0] ba,
	input wire logic [11:0] addr,
	input wire logic lower_byte_mask,
	// decoded view
	input wire logic cmd_pulse,
	input wire logic [3:0] last_cmd,
	input wire logic [1:0] pwr_state,
	input wire logic [11:0] extended_mode_config,
	input wire logic dll_disabled,
	input wire logic [1:0] drive_strength,
	input wire logic [1:0] write_lane_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence mode_set_s;
		!cs_n && !ras_n && !cas_n && !we_n;
	endsequence
	// pins hold after the command, so the past edge still shows its operands
	sequence ext_done_s;
		cmd_pulse && last_cmd == ddr_cmd_pkg::cmd_mode_set && $past(ba) == 2'h1;
	endsequence
	property write_decode_p;
		cmd_pulse && last_cmd == ddr_cmd_pkg::cmd_write |->
			$past(ras_n) && !$past(cas_n) && !$past(we_n);
	endproperty
	property self_refresh_p;
		!cs_n && !ras_n && !cas_n && we_n && $fell(cke) && pwr_state == ddr_cmd_pkg::pwr_normal
			|-> ##[1:2] pwr_state == ddr_cmd_pkg::pwr_self_refresh;
	endproperty
	property wake_p;
		$rose(cke) && (cs_n || (ras_n && cas_n)) && pwr_state != ddr_cmd_pkg::pwr_normal
			|-> ##[1:2] pwr_state == ddr_cmd_pkg::pwr_normal;
	endproperty
	chk_test_bit_low: assert property (mode_set_s |-> !addr[7])
		else $error("test bit set on mode set");
	chk_rsvd_bits_low: assert property (mode_set_s |-> addr[11:9] == 3'h0)
		else $error("reserved bits set on mode set");
	chk_select_one_cycle: assert property (!cs_n |=> cs_n)
		else $error("select held past one cycle");
	chk_write_decode: assert property (write_decode_p)
		else $error("write taken from wrong strobes");
	chk_ext_load: assert property (ext_done_s |-> extended_mode_config == $past(addr))
		else $error("extended word not loaded");
	// decoded fields are registered from the stored word, one edge behind it
	chk_dll_bit: assert property (ext_done_s |=> dll_disabled == $past(addr[0], 2))
		else $error("dll state wrong");
	chk_drive_code: assert property (ext_done_s |=>
		drive_strength == {$past(addr[6], 2), $past(addr[1], 2)})
		else $error("drive code wrong");
	chk_cke_history: assert property (cmd_pulse |-> $past(cke, 2))
		else $error("command taken without prior cke");
	chk_self_refresh: assert property (self_refresh_p)
		else $error("self refresh not entered");
	chk_wake_exit: assert property (wake_p)
		else $error("low power not left");
	chk_nop_after_wake: assert property ($rose(cke) |=> cs_n || (ras_n && cas_n && we_n))
		else $error("no idle command after wake");
	chk_mask_lane: assert property (write_lane_en[0] |-> !$past(lower_byte_mask))
		else $error("masked lane written");
endmodule

// File: test/ddr_command_decode_emr_tb.sv
`timescale 1ns/1ps
`include "ddr_cmd_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module ddr_command_decode_emr_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, cmd_pulse, dll_disabled, test_mode;
	logic illegal_cmd, seen_ill;
	logic [1:0] bresp, rresp, pwr_state, drive_strength, write_lane_en, seen_lanes;
	logic [31:0] rdata;
	logic [3:0] last_cmd, bank_open, seen_cmd;
	logic [11:0] mode_config, extended_mode_config;
	logic [15:0] write_data, seen_data;
	int errors = 0, compares = 0, cyc = 0;
	ddr_cmd_if link_if();
	ddr_cmd_device ddr_cmd_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if),
		.last_cmd(last_cmd), .cmd_pulse(cmd_pulse), .pwr_state(pwr_state),
		.mode_config(mode_config), .extended_mode_config(extended_mode_config),
		.dll_disabled(dll_disabled), .drive_strength(drive_strength), .test_mode(test_mode),
		.bank_open(bank_open), .illegal_cmd(illegal_cmd), .write_data(write_data),
		.write_lane_en(write_lane_en));
	ddr_cmd_controller ddr_cmd_controller_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.link(link_if));
	ddr_command_decode_emr_properties ddr_command_decode_emr_properties_inst (.aclk(aclk),
		.aresetn(aresetn), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
		.we_n(link_if.we_n), .cke(link_if.cke), .ba(link_if.ba), .addr(link_if.addr),
		.lower_byte_mask(link_if.lower_byte_mask), .cmd_pulse(cmd_pulse), .last_cmd(last_cmd),
		.pwr_state(pwr_state), .extended_mode_config(extended_mode_config),
		.dll_disabled(dll_disabled), .drive_strength(drive_strength),
		.write_lane_en(write_lane_en));
	always #2.5 aclk = ~aclk;
	// lane and fault pulses last one cycle, so they are latched here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (write_lane_en !== 2'h0) begin
			seen_lanes <= write_lane_en;
			seen_data <= write_data;
		end
		if (illegal_cmd === 1'b1)
			seen_ill <= 1'b1;
		// the deselect that follows each command issued with cke high also lands in last_cmd
		if (cmd_pulse === 1'b1)
			seen_cmd <= last_cmd;
		if (cyc == 30000) begin
			errors++;
			final_report();
		end
	end
	function automatic logic [11:0] exp_mode(input logic [11:0] a);
		return a & 12'h17f;
	endfunction
	task automatic final_report;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		r = rresp;
		rready <= 1'b0;
	endtask
	// c is {cs_n, ras_n, cas_n, we_n}
	task automatic cmd(input logic k, input logic [3:0] c, input logic [1:0] b, input logic m,
		input logic [11:0] a);
		logic [1:0] r;
		axw(`REG_CMD, {12'h0, k, c, b, m, a}, r);
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		logic [11:0] a, e;
		logic [31:0] d;
		logic [1:0] r;
		static logic [1:0] drv [3] = '{2'h0, 2'h1, 2'h3};
		static logic [3:0] enc [6] = '{4'h3, 4'h5, 4'h6, 4'h4, 4'h2, 4'h1};
		static logic [11:0] adr [6] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h400, 12'h0};
		static ddr_cmd_pkg::cmd_t expc [6] = '{ddr_cmd_pkg::cmd_activate, ddr_cmd_pkg::cmd_read,
			ddr_cmd_pkg::cmd_burst_stop, ddr_cmd_pkg::cmd_write, ddr_cmd_pkg::cmd_precharge,
			ddr_cmd_pkg::cmd_refresh};
		d = $urandom(97);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cmd(1'b1, 4'h7, 2'h0, 1'b0, 12'h0);
		// mode sets issued only with every bank idle
		for (int i = 0; i < 6; i++) begin
			a = 12'($urandom);
			{a[6], a[1]} = drv[i % 3];
			cmd(1'b1, 4'h0, `BA_EXT_MODE, 1'b0, a);
			`CHK(extended_mode_config, exp_mode(a))
			`CHK(dll_disabled, a[0])
			`CHK(drive_strength, drv[i % 3])
			`CHK(test_mode, 1'b0)
		end
		e = extended_mode_config;
		a = 12'($urandom);
		cmd(1'b1, 4'h0, `BA_MODE, 1'b0, a);
		`CHK(mode_config, exp_mode(a))
		`CHK(extended_mode_config, e)
		seen_ill = 1'b0;
		cmd(1'b1, 4'h0, 2'h2, 1'b0, 12'($urandom));
		`CHK(seen_ill, 1'b1)
		`CHK(extended_mode_config, e)
		for (int j = 0; j < 6; j++) begin
			cmd(1'b1, enc[j], 2'h1, 1'b0, adr[j]);
			`CHK(seen_cmd, expc[j])
			if (j == 0)
				`CHK(bank_open, 4'h2)
		end
		`CHK(bank_open, 4'h0)
		cmd(1'b1, 4'h3, 2'h0, 1'b0, 12'h0);
		for (int m = 0; m < 2; m++) begin
			d = $urandom;
			axw(`REG_WDATA, d, r);
			seen_lanes = 2'h0;
			cmd(1'b1, 4'h4, 2'h0, m[0], 12'h0);
			`CHK(seen_lanes, m ? 2'h0 : 2'h3)
			if (m == 0)
				`CHK(seen_data, d[15:0])
		end
		// read with auto-precharge closes its bank
		cmd(1'b1, 4'h5, 2'h0, 1'b0, 12'h400);
		`CHK(seen_cmd, ddr_cmd_pkg::cmd_read)
		`CHK(bank_open, 4'h0)
		cmd(1'b1, 4'h2, 2'h0, 1'b0, 12'h400);
		cmd(1'b0, 4'h7, 2'h0, 1'b0, 12'h0);
		`CHK(pwr_state, ddr_cmd_pkg::pwr_down)
		cmd(1'b1, 4'h7, 2'h0, 1'b0, 12'h0);
		`CHK(pwr_state, ddr_cmd_pkg::pwr_normal)
		// dll restarted through the extended word after leaving power-down
		cmd(1'b1, 4'h0, `BA_EXT_MODE, 1'b0, 12'h000);
		`CHK(extended_mode_config, 12'h000)
		`CHK(dll_disabled, 1'b0)
		cmd(1'b0, 4'h1, 2'h0, 1'b0, 12'h0);
		`CHK(pwr_state, ddr_cmd_pkg::pwr_self_refresh)
		cmd(1'b1, 4'h7, 2'h0, 1'b0, 12'h0);
		`CHK(pwr_state, ddr_cmd_pkg::pwr_normal)
		axw(`REG_STATUS, 32'h1, r);
		`CHK(r, 2'h2)
		axr(`REG_ADDR, r);
		`CHK(r, 2'h2)
		axr(`REG_WDATA, r);
		`CHK(r, 2'h0)
		`CHK(rdata, 32'(d[15:0]))
		final_report();
	end
endmodule
